// ---- rtl/lcrc_pkg.sv ----
// Shared constants, types and check-code functions for the link CRC block.
package lcrc_pkg;

	localparam logic [15:0] CRC16_POLY_REFL = 16'hA001;
	localparam logic [7:0] CRC8_POLY_REFL = 8'h8C;
	localparam logic [15:0] CRC16_CLEAR = 16'h0000;
	localparam logic [7:0] CRC8_CLEAR = 8'h00;
	localparam logic [7:0] PAD_BYTE = 8'hFF;
	localparam logic [7:0] ADDR_LO_WRITE_MASK = 8'hF8;
	localparam int SP_BYTES = 8;
	localparam int PAGE_BYTES = 32;
	localparam int CODE_BYTES = 20;
	localparam int ID_BYTES = 8;
	localparam int ID_BODY_BITS = 56;
	localparam int OFF_W = 5;

	typedef enum logic [1:0] {
		KIND_WRITE_SP = 2'h0,
		KIND_READ_SP = 2'h1,
		KIND_AUTH_PAGE = 2'h2,
		KIND_READ_ID = 2'h3
	} lcrc_kind_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_HDR = 3'h1,
		ST_DATA = 3'h3,
		ST_PAD = 3'h2,
		ST_CRC_LO = 3'h6,
		ST_CRC_HI = 3'h7,
		ST_CODE = 3'h5,
		ST_ID = 3'h4
	} lcrc_state_e;

	// Shifts one byte into the 16-bit generator, least significant bit first.
	function automatic logic [15:0] crc16_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ CRC16_POLY_REFL;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	// Computes the 8-bit check over the 56-bit identity body, LSB first.
	function automatic logic [7:0] crc8_body(input logic [55:0] d);
		logic [7:0] r;
		r = CRC8_CLEAR;
		for (int i = 0; i < ID_BODY_BITS; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ CRC8_POLY_REFL;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

endpackage

// ---- rtl/lcrc_crc_if.sv ----
// Control and result signals between the sequencer and the CRC-16 engine.
`timescale 1ns/10ps
interface lcrc_crc_if;
	logic clear;
	logic step;
	logic [7:0] data;
	logic [15:0] value;
	modport ctrl(output clear, output step, output data, input value);
	modport engine(input clear, input step, input data, output value);
endinterface

// ---- rtl/lcrc_crc16.sv ----
// CRC-16 generator engine, one byte per clock.
`timescale 1ns/10ps
module lcrc_crc16 (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	lcrc_crc_if.engine crc // Clear, step and result.
);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			crc.value <= lcrc_pkg::CRC16_CLEAR;
		end else if (crc.clear && crc.step) begin
			crc.value <= lcrc_pkg::crc16_byte(lcrc_pkg::CRC16_CLEAR,
				crc.data);
		end else if (crc.clear) begin
			crc.value <= lcrc_pkg::CRC16_CLEAR;
		end else if (crc.step) begin
			crc.value <= lcrc_pkg::crc16_byte(crc.value, crc.data);
		end
	end

	AST_STEP_LSB: assert property (@(posedge clk) disable iff (!rst_n)
		(crc.step && !crc.clear) |=> crc.value ==
		lcrc_pkg::crc16_byte($past(crc.value), $past(crc.data)))
		else $error("CRC-16 step result wrong.");

endmodule

// ---- rtl/lcrc_top.sv ----
// Check-code sequencer for identity reads and CRC-16 covered transfers.
// How it works
// - Identity top byte holds 8-bit CRC.
// - Identity CRC is sent uninverted.
// - CRC-16 engine serves writes, reads, page reads.
// - CRC-16 always sent complemented.
// - Write: clear, command, masked low address, high address, data.
// - Write CRC sent only at scratchpad end.
// - Read covers command, addresses, status, data.
// - Read CRC sent only past last byte.
// - Page read covers header, data, FFh pad.
// - Fresh CRC over authentication code afterwards.
// - Identity is family, serial, CRC in order.
`timescale 1ns/10ps
module lcrc_top #(
	parameter logic [7:0] FAMILY_CODE = 8'h5A, // Arbitrary value.
	parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789AB, // Arbitrary.
	parameter int SP_BYTES = lcrc_pkg::SP_BYTES,
	parameter int PAGE_BYTES = lcrc_pkg::PAGE_BYTES,
	parameter int CODE_BYTES = lcrc_pkg::CODE_BYTES
) (
	input wire logic clk, // System clock, 40 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic cmd_start, // Pulse: a new command begins.
	input wire logic [1:0] cmd_kind, // Kind of command, with cmd_start.
	input wire logic [7:0] cmd_byte, // Command code, with cmd_start.
	input wire logic link_valid, // Pulse: a covered byte crossed the link.
	input wire logic [7:0] link_byte, // That byte.
	input wire logic tx_ack, // Pulse: link has taken tx_byte.
	output logic tx_due, // Level: tx_byte must be sent next.
	output logic [7:0] tx_byte, // Check or identity byte to send.
	output logic busy // Level: a command is in progress.
);

	localparam logic [55:0] ID_BODY = {SERIAL_NUMBER, FAMILY_CODE};
	localparam logic [63:0] ID_WORD = {lcrc_pkg::crc8_body(ID_BODY),
		ID_BODY};
	localparam logic [4:0] SP_LAST = 5'(SP_BYTES - 1);
	localparam logic [4:0] PAGE_LAST = 5'(PAGE_BYTES - 1);
	localparam logic [4:0] CODE_LAST = 5'(CODE_BYTES - 1);
	localparam logic [4:0] ID_LAST = 5'(lcrc_pkg::ID_BYTES - 1);

	lcrc_pkg::lcrc_state_e state_reg, state_next;
	lcrc_pkg::lcrc_kind_e kind_reg, kind_in;
	logic hdr_cnt_reg;
	logic es_pend_reg;
	logic code_phase_reg;
	logic [4:0] off_reg;
	logic tx_due_reg;
	logic [7:0] tx_byte_reg;
	logic busy_reg;
	logic take, ack_take, data_end, code_end, to_code;
	logic [4:0] last_off;

	lcrc_crc_if crc_bus ();

	lcrc_crc16 u_crc16 (
		.clk(clk),
		.rst_n(rst_n),
		.crc(crc_bus.engine)
	);

	assign kind_in = lcrc_pkg::lcrc_kind_e'(cmd_kind);
	assign take = link_valid && (state_reg == lcrc_pkg::ST_HDR
		|| state_reg == lcrc_pkg::ST_DATA || state_reg == lcrc_pkg::ST_CODE);
	assign ack_take = tx_ack && tx_due_reg;
	assign last_off = (kind_reg == lcrc_pkg::KIND_AUTH_PAGE) ? PAGE_LAST
		: SP_LAST;
	// The status byte of a read precedes the data and is not counted.
	assign data_end = take && state_reg == lcrc_pkg::ST_DATA
		&& !es_pend_reg && off_reg == last_off;
	assign code_end = take && state_reg == lcrc_pkg::ST_CODE
		&& off_reg == CODE_LAST;
	assign to_code = state_reg == lcrc_pkg::ST_CRC_HI && ack_take
		&& kind_reg == lcrc_pkg::KIND_AUTH_PAGE && !code_phase_reg;

	always_comb begin
		state_next = state_reg;
		if (cmd_start) begin
			state_next = (kind_in == lcrc_pkg::KIND_READ_ID)
				? lcrc_pkg::ST_ID : lcrc_pkg::ST_HDR;
		end else begin
			unique case (state_reg)
				lcrc_pkg::ST_IDLE: begin
					state_next = lcrc_pkg::ST_IDLE;
				end
				lcrc_pkg::ST_HDR: begin
					if (take && hdr_cnt_reg) begin
						state_next = lcrc_pkg::ST_DATA;
					end
				end
				lcrc_pkg::ST_DATA: begin
					if (data_end) begin
						state_next = (kind_reg == lcrc_pkg::KIND_AUTH_PAGE)
							? lcrc_pkg::ST_PAD : lcrc_pkg::ST_CRC_LO;
					end
				end
				lcrc_pkg::ST_PAD: begin
					state_next = lcrc_pkg::ST_CRC_LO;
				end
				lcrc_pkg::ST_CRC_LO: begin
					if (ack_take) begin
						state_next = lcrc_pkg::ST_CRC_HI;
					end
				end
				lcrc_pkg::ST_CRC_HI: begin
					if (to_code) begin
						state_next = lcrc_pkg::ST_CODE;
					end else if (ack_take) begin
						state_next = lcrc_pkg::ST_IDLE;
					end
				end
				lcrc_pkg::ST_CODE: begin
					if (code_end) begin
						state_next = lcrc_pkg::ST_CRC_LO;
					end
				end
				lcrc_pkg::ST_ID: begin
					if (ack_take && off_reg == ID_LAST) begin
						state_next = lcrc_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// A new command always wins over a byte that arrives with it.
	always_comb begin
		crc_bus.clear = cmd_start || to_code;
		crc_bus.step = (cmd_start && kind_in != lcrc_pkg::KIND_READ_ID)
			|| (!cmd_start && (take || state_reg == lcrc_pkg::ST_PAD));
		if (cmd_start) begin
			crc_bus.data = cmd_byte;
		end else if (state_reg == lcrc_pkg::ST_PAD) begin
			crc_bus.data = lcrc_pkg::PAD_BYTE;
		end else if (state_reg == lcrc_pkg::ST_HDR && !hdr_cnt_reg
			&& kind_reg == lcrc_pkg::KIND_WRITE_SP) begin
			crc_bus.data = link_byte & lcrc_pkg::ADDR_LO_WRITE_MASK;
		end else begin
			crc_bus.data = link_byte;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= lcrc_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			kind_reg <= lcrc_pkg::KIND_WRITE_SP;
			hdr_cnt_reg <= 1'b0;
			es_pend_reg <= 1'b0;
			code_phase_reg <= 1'b0;
		end else if (cmd_start) begin
			kind_reg <= kind_in;
			hdr_cnt_reg <= 1'b0;
			es_pend_reg <= (kind_in == lcrc_pkg::KIND_READ_SP);
			code_phase_reg <= 1'b0;
		end else begin
			if (take && state_reg == lcrc_pkg::ST_HDR) begin
				hdr_cnt_reg <= 1'b1;
			end
			if (take && state_reg == lcrc_pkg::ST_DATA) begin
				es_pend_reg <= 1'b0;
			end
			if (to_code) begin
				code_phase_reg <= 1'b1;
			end
		end
	end

	// Offset within the data, then the code byte count, then identity index.
	always_ff @(posedge clk) begin
		if (!rst_n || cmd_start || to_code) begin
			off_reg <= 5'h00;
		end else if (take && state_reg == lcrc_pkg::ST_HDR && !hdr_cnt_reg) begin
			if (kind_reg == lcrc_pkg::KIND_AUTH_PAGE) begin
				off_reg <= link_byte[4:0];
			end else if (kind_reg == lcrc_pkg::KIND_READ_SP) begin
				off_reg <= {2'h0, link_byte[2:0]};
			end else begin
				off_reg <= 5'h00;
			end
		end else if ((take && state_reg == lcrc_pkg::ST_DATA && !es_pend_reg)
			|| (take && state_reg == lcrc_pkg::ST_CODE)
			|| (ack_take && state_reg == lcrc_pkg::ST_ID)) begin
			off_reg <= off_reg + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_due_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
		end else begin
			tx_due_reg <= !cmd_start && !ack_take
				&& (state_reg == lcrc_pkg::ST_CRC_LO
				|| state_reg == lcrc_pkg::ST_CRC_HI
				|| state_reg == lcrc_pkg::ST_ID);
			if (state_reg == lcrc_pkg::ST_CRC_LO) begin
				tx_byte_reg <= ~crc_bus.value[7:0];
			end else if (state_reg == lcrc_pkg::ST_CRC_HI) begin
				tx_byte_reg <= ~crc_bus.value[15:8];
			end else if (state_reg == lcrc_pkg::ST_ID) begin
				tx_byte_reg <= ID_WORD[{off_reg[2:0], 3'h0} +: 8];
			end else begin
				tx_byte_reg <= 8'h00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= (state_next != lcrc_pkg::ST_IDLE);
		end
	end

	assign tx_due = tx_due_reg;
	assign tx_byte = tx_byte_reg;
	assign busy = busy_reg;

	sequence s_lo_ack;
		state_reg == lcrc_pkg::ST_CRC_LO && ack_take && !cmd_start;
	endsequence

	sequence s_hi_shown;
		!tx_due_reg ##1 (tx_due_reg && tx_byte_reg == ~crc_bus.value[15:8]);
	endsequence

	AST_CRC_HI_NEXT: assert property (@(posedge clk) disable iff (!rst_n)
		s_lo_ack ##1 !cmd_start |-> s_hi_shown)
		else $error("High check byte not presented after low byte.");

	AST_CRC_LO_INV: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == lcrc_pkg::ST_CRC_LO && tx_due_reg)
		|-> tx_byte_reg == ~crc_bus.value[7:0])
		else $error("Low check byte not complemented.");

	AST_ID_CRC_TRUE: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == lcrc_pkg::ST_ID && off_reg == ID_LAST && tx_due_reg)
		|-> tx_byte_reg == lcrc_pkg::crc8_body(ID_BODY))
		else $error("Identity check byte wrong or inverted.");

	AST_CMD_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		(cmd_start && kind_in != lcrc_pkg::KIND_READ_ID) |=> crc_bus.value
		== lcrc_pkg::crc16_byte(lcrc_pkg::CRC16_CLEAR, $past(cmd_byte)))
		else $error("Generator not cleared before command code.");

	AST_LOW_MASK: assert property (@(posedge clk) disable iff (!rst_n)
		(take && !cmd_start && state_reg == lcrc_pkg::ST_HDR && !hdr_cnt_reg
		&& kind_reg == lcrc_pkg::KIND_WRITE_SP) |-> crc_bus.data[2:0] == 3'h0)
		else $error("Low address bits not forced to zero.");

	AST_WR_NO_CRC: assert property (@(posedge clk) disable iff (!rst_n)
		(take && !cmd_start && state_reg == lcrc_pkg::ST_DATA
		&& kind_reg == lcrc_pkg::KIND_WRITE_SP && off_reg != SP_LAST)
		|=> state_reg == lcrc_pkg::ST_DATA && !tx_due_reg)
		else $error("Write check sent before scratchpad end.");

	AST_RD_CRC_END: assert property (@(posedge clk) disable iff (!rst_n)
		(data_end && !cmd_start && kind_reg == lcrc_pkg::KIND_READ_SP)
		##1 !cmd_start |-> state_reg == lcrc_pkg::ST_CRC_LO ##1 tx_due_reg)
		else $error("Read check not offered after last byte.");

	AST_PAD_FF: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == lcrc_pkg::ST_PAD && !cmd_start) |-> (crc_bus.step
		&& crc_bus.data == lcrc_pkg::PAD_BYTE) ##1
		state_reg == lcrc_pkg::ST_CRC_LO)
		else $error("Pad byte not shifted before page check.");

	AST_CODE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		(to_code && !cmd_start) |=> crc_bus.value == lcrc_pkg::CRC16_CLEAR
		&& state_reg == lcrc_pkg::ST_CODE && off_reg == 5'h00)
		else $error("Generator not cleared before code bytes.");

endmodule

// ---- tb/lcrc_master_model.sv ----
// Link-side master model that takes check and identity bytes.
`timescale 1ns/10ps
module lcrc_master_model (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic tx_due, // Byte offered by the block.
	input wire logic [7:0] tx_byte, // Offered byte.
	input wire logic [1:0] ack_wait, // Cycles to stall before taking.
	output logic tx_ack // Byte taken.
);
	logic [7:0] rx_q[$];
	int waited = 0;
	initial tx_ack = 1'b0;
	// The ack is held until the edge that takes it, then released.
	always @(negedge clk) begin
		if (!tx_due || tx_ack || !rst_n) begin
			tx_ack <= 1'b0;
			waited <= 0;
		end else if (waited >= int'(ack_wait)) begin
			tx_ack <= 1'b1;
		end else begin
			waited <= waited + 1;
		end
	end
	always @(posedge clk) begin
		if (tx_due && tx_ack) begin
			rx_q.push_back(tx_byte);
		end
	end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the link CRC sequencer.
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_start = 1'b0;
	logic [1:0] cmd_kind = 2'h0;
	logic [7:0] cmd_byte = 8'h00;
	logic link_valid = 1'b0;
	logic [7:0] link_byte = 8'h00;
	logic [1:0] ack_wait = 2'h0;
	logic tx_ack;
	logic tx_due;
	logic busy;
	logic [7:0] tx_byte;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h00001A55;
	logic [7:0] exp_q[$];
	logic [15:0] crc;
	always #12.5 clk = ~clk;
	lcrc_top lcrc_top_i (.clk(clk), .rst_n(rst_n), .cmd_start(cmd_start),
		.cmd_kind(cmd_kind), .cmd_byte(cmd_byte), .link_valid(link_valid),
		.link_byte(link_byte), .tx_ack(tx_ack), .tx_due(tx_due),
		.tx_byte(tx_byte), .busy(busy));
	lcrc_master_model lcrc_master_model_i (.clk(clk), .rst_n(rst_n),
		.tx_due(tx_due), .tx_byte(tx_byte), .ack_wait(ack_wait),
		.tx_ack(tx_ack));
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic [15:0] crc16(input logic [15:0] c,
		input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'hA001 : 16'h0000);
		return c;
	endfunction
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
			c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
		return c;
	endfunction
	task automatic summarize();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end
	// Called at a falling edge; returns at the next one.
	task automatic start(input logic [1:0] k);
		logic [7:0] c;
		c = rnd();
		cmd_start = 1'b1;
		cmd_kind = k;
		cmd_byte = c;
		ack_wait = c[1:0];
		crc = (k == 2'h3) ? 16'h0000 : crc16(16'h0000, c);
		exp_q.delete();
		lcrc_master_model_i.rx_q.delete();
		@(negedge clk);
		cmd_start = 1'b0;
	endtask
	// Sends one byte on the link and shifts s into the expected check.
	task automatic put(input logic [7:0] b, input logic [7:0] s);
		link_valid = 1'b1;
		link_byte = b;
		crc = crc16(crc, s);
		@(negedge clk);
	endtask
	task automatic push_crc();
		exp_q.push_back(~crc[7:0]);
		exp_q.push_back(~crc[15:8]);
	endtask
	task automatic drain();
		link_valid = 1'b0;
		repeat (10) @(negedge clk);
		for (int i = 0; i < 300; i++)
			if (lcrc_master_model_i.rx_q.size() < exp_q.size())
				@(negedge clk);
		chk(16'(lcrc_master_model_i.rx_q.size()), 16'(exp_q.size()));
		foreach (exp_q[i])
			if (i < lcrc_master_model_i.rx_q.size())
				chk({8'h00, lcrc_master_model_i.rx_q[i]}, {8'h00, exp_q[i]});
	endtask
	initial begin
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
		logic [7:0] b;
		int n;
		repeat (20) @(negedge clk);
		chk({6'h00, tx_due, busy, tx_byte}, 16'h0000);
		rst_n = 1'b1;
		@(negedge clk);
		chk({6'h00, tx_due, busy, tx_byte}, 16'h0000);
		start(2'h3);
		exp_q = {8'h5A, 8'hAB, 8'h89, 8'h67, 8'h45, 8'h23, 8'h01,
			crc8({48'h0123456789AB, 8'h5A})};
		drain();
		chk({15'h0000, busy}, 16'h0000);
		for (int r = 0; r < 6; r++) begin
			start(2'h0);
			addr_lo = rnd();
			addr_hi = rnd();
			put(addr_lo, addr_lo & 8'hF8);
			put(addr_hi, addr_hi);
			n = (r % 2 == 1) ? 8 : r + 1;
			repeat (n) begin
				b = rnd();
				put(b, b);
			end
			if (n == 8)
				push_crc();
			drain();
			start(2'h1);
			addr_lo = rnd();
			addr_hi = rnd();
			b = rnd();
			put(addr_lo, addr_lo);
			put(addr_hi, addr_hi);
			put(b, b);
			for (int i = addr_lo[2:0]; i < 8; i++)
				put(rnd(), 8'h00);
			crc = 16'h0000;
			start(2'h1);
			put(addr_lo, addr_lo);
			put(addr_hi, addr_hi);
			put(b, b);
			for (int i = addr_lo[2:0]; i < 8; i++) begin
				b = rnd();
				put(b, b);
			end
			push_crc();
			drain();
			chk({15'h0000, busy}, 16'h0000);
			start(2'h2);
			addr_lo = rnd();
			addr_hi = rnd();
			put(addr_lo, addr_lo);
			put(addr_hi, addr_hi);
			for (int i = addr_lo[4:0]; i < 32; i++) begin
				b = rnd();
				put(b, b);
			end
			crc = crc16(crc, 8'hFF);
			push_crc();
			drain();
			crc = 16'h0000;
			repeat (20) begin
				b = rnd();
				put(b, b);
			end
			push_crc();
			drain();
		end
		summarize();
	end
endmodule
